// *** sixbm_pkg.sv ***
// Shared constants for the six-layer bus matrix
`default_nettype none
package sixbm_pkg;
  // Matrix size
  localparam int NM = 6;
  localparam int NS = 5;
  localparam int SLOTW = 8;

  // Transfer types
  localparam logic [1:0] TR_IDLE   = 2'h0;
  localparam logic [1:0] TR_BUSY   = 2'h1;
  localparam logic [1:0] TR_NONSEQ = 2'h2;
  localparam logic [1:0] TR_SEQ    = 2'h3;

  // Slave indices
  localparam logic [2:0] SL_SRAM0 = 3'h0;
  localparam logic [2:0] SL_SRAM1 = 3'h1;
  localparam logic [2:0] SL_ROM   = 3'h2;
  localparam logic [2:0] SL_EXT   = 3'h3;
  localparam logic [2:0] SL_PERI  = 3'h4;

  // First level decode: 256 MB banks on address bits 31..28
  localparam int BANK_MSB = 31;
  localparam int BANK_LSB = 28;
  localparam logic [3:0] BANK_INT    = 4'h0;
  localparam logic [3:0] BANK_EXT_LO = 4'h1;
  localparam logic [3:0] BANK_EXT_HI = 4'h7;
  localparam logic [3:0] BANK_PERI   = 4'hF;

  // Second level decode inside bank 0: 1 MB areas on bits 27..20
  localparam int AREA_MSB = 27;
  localparam int AREA_LSB = 20;
  localparam logic [7:0] AREA_BOOT  = 8'h00;
  localparam logic [7:0] AREA_ROM   = 8'h01;
  localparam logic [7:0] AREA_SRAM0 = 8'h02;
  localparam logic [7:0] AREA_SRAM1 = 8'h03;
  localparam logic [7:0] AREA_USB   = 8'h05;

  // Which masters may reach each slave, bit m for master m
  localparam logic [NS-1:0][NM-1:0] ACC_TAB = {6'h0F, 6'h3F, 6'h0F, 6'h3F, 6'h3F};
  localparam logic [NM-1:0] ACC_USB = 6'h03;

  // Arbitration settings
  localparam logic       ARB_FIXED = 1'b0;
  localparam logic       ARB_RR    = 1'b1;
  localparam logic [1:0] DEF_NONE  = 2'h0;
  localparam logic [1:0] DEF_LAST  = 2'h1;
  localparam logic [1:0] DEF_FIXED = 2'h2;

  // Boot select value assumed before the pin has been captured
  localparam logic BOOT_ROM_RST = 1'b1;
endpackage
`default_nettype wire

// *** sixbm_arbiter.sv ***
// Per-slave arbiter with fixed or round-robin choice, default master and slot limit
`timescale 1ns/100ps
`default_nettype none
module sixbm_arbiter #(
  parameter int NM    = sixbm_pkg::NM,
  parameter int SLOTW = sixbm_pkg::SLOTW
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [NM-1:0]    req,
  input  wire logic             rr_mode,
  input  wire logic [1:0]       dflt_mode,
  input  wire logic [2:0]       dflt_master,
  input  wire logic [SLOTW-1:0] slot_limit,
  output logic                  owner_vld,
  output logic [2:0]            owner
);
  logic [2:0]       owner_r;
  logic [2:0]       owner_nxt;
  logic             vld_r;
  logic             vld_nxt;
  logic [2:0]       last_r;
  logic [2:0]       last_nxt;
  logic [SLOTW-1:0] slot_r;
  logic [SLOTW-1:0] slot_nxt;

  // Next owner: hold while requested, break on slot expiry, else pick or park
  always_comb
  begin
    logic       expire;
    logic       hold;
    logic       found;
    logic [2:0] win;
    logic [3:0] k;
    logic [NM-1:0] others;
    expire = 1'b0;
    hold = 1'b0;
    found = 1'b0;
    win = 3'h0;
    k = 4'h0;
    others = req;
    if (vld_r)
      others[owner_r] = 1'b0;
    expire = (slot_limit != '0) && (slot_r >= slot_limit) && (|others);
    hold = vld_r && req[owner_r] && !expire;
    for (int i = 0; i < NM; i++)
    begin
      if (rr_mode == sixbm_pkg::ARB_RR)
      begin
        k = 4'(last_r) + 4'(i) + 4'h1;
        if (k >= 4'(NM))
          k = k - 4'(NM);
      end
      else
        k = 4'(i);
      if (!found && req[k[2:0]] && !(expire && vld_r && k[2:0] == owner_r))
      begin
        found = 1'b1;
        win = k[2:0];
      end
    end
    owner_nxt = owner_r;
    vld_nxt = vld_r;
    last_nxt = last_r;
    slot_nxt = slot_r;
    if (hold)
    begin
      if (slot_r != '1)
        slot_nxt = SLOTW'(slot_r + 1'b1);
    end
    else if (found)
    begin
      owner_nxt = win;
      vld_nxt = 1'b1;
      last_nxt = win;
      slot_nxt = '0;
    end
    else
    begin
      // Parking on a default master saves the arbitration cycle when it returns
      slot_nxt = '0;
      case (dflt_mode)
        sixbm_pkg::DEF_LAST:
        begin
          owner_nxt = last_r;
          vld_nxt = 1'b1;
        end
        sixbm_pkg::DEF_FIXED:
        begin
          owner_nxt = dflt_master;
          vld_nxt = 1'b1;
        end
        default:
          vld_nxt = 1'b0;
      endcase
    end
  end

  // Arbiter state
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      owner_r <= 3'h0;
      vld_r   <= 1'b0;
      last_r  <= 3'h0;
      slot_r  <= '0;
    end
    else
    begin
      owner_r <= owner_nxt;
      vld_r   <= vld_nxt;
      last_r  <= last_nxt;
      slot_r  <= slot_nxt;
    end
  end

  assign owner_vld = vld_r;
  assign owner     = owner_r;
endmodule
`default_nettype wire

// *** sixbm_matrix.sv ***
// Six-master, five-slave bus matrix with per-master decode and per-slave arbitration
`timescale 1ns/100ps
`default_nettype none
module sixbm_matrix #(
  parameter int DW    = 32,
  parameter int SLOTW = sixbm_pkg::SLOTW
) (
  input  wire logic                                  clk_sys,
  input  wire logic                                  sys_rst,
  input  wire logic                                  boot_memory_select,
  input  wire logic                                  remap_en,
  input  wire logic [sixbm_pkg::NS-1:0]              arb_rr_mode,
  input  wire logic [sixbm_pkg::NS-1:0][1:0]         arb_dflt_mode,
  input  wire logic [sixbm_pkg::NS-1:0][2:0]         arb_dflt_master,
  input  wire logic [sixbm_pkg::NS-1:0][SLOTW-1:0]   arb_slot_limit,
  input  wire logic [sixbm_pkg::NM-1:0][1:0]         m_htrans,
  input  wire logic [sixbm_pkg::NM-1:0][31:0]        m_haddr,
  input  wire logic [sixbm_pkg::NM-1:0]              m_hwrite,
  input  wire logic [sixbm_pkg::NM-1:0][2:0]         m_hsize,
  input  wire logic [sixbm_pkg::NM-1:0][2:0]         m_hburst,
  input  wire logic [sixbm_pkg::NM-1:0][DW-1:0]      m_hwdata,
  output logic      [sixbm_pkg::NM-1:0]              m_hready,
  output logic      [sixbm_pkg::NM-1:0]              m_hresp,
  output logic      [sixbm_pkg::NM-1:0][DW-1:0]      m_hrdata,
  output logic      [sixbm_pkg::NS-1:0]              s_hsel,
  output logic      [sixbm_pkg::NS-1:0][31:0]        s_haddr,
  output logic      [sixbm_pkg::NS-1:0][1:0]         s_htrans,
  output logic      [sixbm_pkg::NS-1:0]              s_hwrite,
  output logic      [sixbm_pkg::NS-1:0][2:0]         s_hsize,
  output logic      [sixbm_pkg::NS-1:0][2:0]         s_hburst,
  output logic      [sixbm_pkg::NS-1:0][DW-1:0]      s_hwdata,
  output logic      [sixbm_pkg::NS-1:0][2:0]         s_hmaster,
  input  wire logic [sixbm_pkg::NS-1:0]              s_hready,
  input  wire logic [sixbm_pkg::NS-1:0]              s_hresp,
  input  wire logic [sixbm_pkg::NS-1:0][DW-1:0]      s_hrdata,
  output logic                                       boot_from_rom
);
  localparam int NM = sixbm_pkg::NM;
  localparam int NS = sixbm_pkg::NS;

  logic [2:0]                 bsel_sync_r;
  logic [2:0]                 bsel_sync_nxt;
  logic                       bsel_done_r;
  logic                       bsel_done_nxt;
  logic                       boot_rom_r;
  logic                       boot_rom_nxt;
  logic [NM-1:0][2:0]         dec_slv;
  logic [NM-1:0]              dec_hit;
  logic [NM-1:0]              act;
  logic [NS-1:0][NM-1:0]      sreq;
  logic [NS-1:0]              own_vld;
  logic [NS-1:0][2:0]         own;
  logic [NS-1:0]              sdone;
  logic [NM-1:0]              mdone;
  logic [NM-1:0]              m_hready_r;
  logic [NM-1:0]              m_hready_nxt;
  logic [NM-1:0]              m_hresp_r;
  logic [NM-1:0]              m_hresp_nxt;
  logic [NM-1:0][DW-1:0]      m_hrdata_r;
  logic [NM-1:0][DW-1:0]      m_hrdata_nxt;
  logic [NS-1:0]              s_hsel_r;
  logic [NS-1:0]              s_hsel_nxt;
  logic [NS-1:0][31:0]        s_haddr_r;
  logic [NS-1:0][31:0]        s_haddr_nxt;
  logic [NS-1:0][1:0]         s_htrans_r;
  logic [NS-1:0][1:0]         s_htrans_nxt;
  logic [NS-1:0]              s_hwrite_r;
  logic [NS-1:0]              s_hwrite_nxt;
  logic [NS-1:0][2:0]         s_hsize_r;
  logic [NS-1:0][2:0]         s_hsize_nxt;
  logic [NS-1:0][2:0]         s_hburst_r;
  logic [NS-1:0][2:0]         s_hburst_nxt;
  logic [NS-1:0][DW-1:0]      s_hwdata_r;
  logic [NS-1:0][DW-1:0]      s_hwdata_nxt;
  logic [NS-1:0][2:0]         s_hmaster_r;
  logic [NS-1:0][2:0]         s_hmaster_nxt;

  // Boot select capture: pin passes three flops, first stable value is kept
  always_comb
  begin
    bsel_sync_nxt = {bsel_sync_r[1:0], boot_memory_select};
    bsel_done_nxt = bsel_done_r;
    boot_rom_nxt  = boot_rom_r;
    if (!bsel_done_r && (bsel_sync_r[1] == bsel_sync_r[2]))
    begin
      boot_rom_nxt  = bsel_sync_r[2];
      bsel_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bsel_sync_r <= 3'h2; // Stages 1 and 2 disagree until the pin has filled them, no capture of reset junk
      bsel_done_r <= 1'b0;
      boot_rom_r  <= sixbm_pkg::BOOT_ROM_RST;
    end
    else
    begin
      bsel_sync_r <= bsel_sync_nxt;
      bsel_done_r <= bsel_done_nxt;
      boot_rom_r  <= boot_rom_nxt;
    end
  end

  // Per-master decoders, all on the same map; hit also folds in the path table
  always_comb
  begin
    logic [3:0]    bank;
    logic [7:0]    area;
    logic          mapped;
    logic [NM-1:0] acc;
    bank = 4'h0;
    area = 8'h00;
    mapped = 1'b0;
    acc = '0;
    for (int m = 0; m < NM; m++)
    begin
      bank = m_haddr[m][sixbm_pkg::BANK_MSB:sixbm_pkg::BANK_LSB];
      area = m_haddr[m][sixbm_pkg::AREA_MSB:sixbm_pkg::AREA_LSB];
      mapped = 1'b1;
      dec_slv[m] = sixbm_pkg::SL_EXT;
      acc = '0;
      if (bank == sixbm_pkg::BANK_INT)
      begin
        case (area)
          sixbm_pkg::AREA_BOOT:
            dec_slv[m] = remap_en ? sixbm_pkg::SL_SRAM0 : (boot_rom_r ? sixbm_pkg::SL_ROM : sixbm_pkg::SL_EXT);
          sixbm_pkg::AREA_ROM:   dec_slv[m] = sixbm_pkg::SL_ROM;
          sixbm_pkg::AREA_SRAM0: dec_slv[m] = sixbm_pkg::SL_SRAM0;
          sixbm_pkg::AREA_SRAM1: dec_slv[m] = sixbm_pkg::SL_SRAM1;
          sixbm_pkg::AREA_USB:   dec_slv[m] = sixbm_pkg::SL_ROM;
          default:               mapped = 1'b0;
        endcase
      end
      else if (bank == sixbm_pkg::BANK_PERI)
        dec_slv[m] = sixbm_pkg::SL_PERI;
      else if (bank < sixbm_pkg::BANK_EXT_LO || bank > sixbm_pkg::BANK_EXT_HI)
        mapped = 1'b0;
      acc = sixbm_pkg::ACC_TAB[dec_slv[m]];
      if (bank == sixbm_pkg::BANK_INT && area == sixbm_pkg::AREA_USB)
        acc = sixbm_pkg::ACC_USB;
      dec_hit[m] = mapped && acc[m];
      act[m] = m_htrans[m][1];
    end
  end

  // Requests per slave; a request stays up while the master drives NONSEQ or SEQ, a BUSY beat drops it
  always_comb
  begin
    for (int s = 0; s < NS; s++)
      for (int m = 0; m < NM; m++)
        sreq[s][m] = act[m] && dec_hit[m] && (dec_slv[m] == 3'(s));
  end

  // One arbiter per slave, each with its own settings
  for (genvar g = 0; g < NS; g++)
  begin : g_arb
    sixbm_arbiter #(
      .NM    (NM),
      .SLOTW (SLOTW)
    ) u_arb (
      .clk_sys     (clk_sys),
      .sys_rst     (sys_rst),
      .req         (sreq[g]),
      .rr_mode     (arb_rr_mode[g]),
      .dflt_mode   (arb_dflt_mode[g]),
      .dflt_master (arb_dflt_master[g]),
      .slot_limit  (arb_slot_limit[g]),
      .owner_vld   (own_vld[g]),
      .owner       (own[g])
    );
  end

  // Completion of the transfer presented to each slave
  always_comb
  begin
    mdone = '0;
    for (int s = 0; s < NS; s++)
    begin
      sdone[s] = s_hsel_r[s] && s_hready[s];
      if (sdone[s])
        mdone[s_hmaster_r[s]] = 1'b1;
    end
  end

  // Slave side: issue the granted master's request, hold while the slave stalls
  always_comb
  begin
    logic [2:0] o;
    o = 3'h0;
    s_hsel_nxt    = s_hsel_r;
    s_haddr_nxt   = s_haddr_r;
    s_htrans_nxt  = s_htrans_r;
    s_hwrite_nxt  = s_hwrite_r;
    s_hsize_nxt   = s_hsize_r;
    s_hburst_nxt  = s_hburst_r;
    s_hwdata_nxt  = s_hwdata_r;
    s_hmaster_nxt = s_hmaster_r;
    for (int s = 0; s < NS; s++)
    begin
      o = own[s];
      if (!(s_hsel_r[s] && !s_hready[s]))
      begin
        // Masked while the answer is in flight so one request never issues twice
        s_hsel_nxt[s] = own_vld[s] && sreq[s][o] && !mdone[o] && !m_hready_r[o];
        s_htrans_nxt[s] = s_hsel_nxt[s] ? m_htrans[o] : sixbm_pkg::TR_IDLE;
        s_haddr_nxt[s]   = m_haddr[o];
        s_hwrite_nxt[s]  = m_hwrite[o];
        s_hsize_nxt[s]   = m_hsize[o];
        s_hburst_nxt[s]  = m_hburst[o];
        s_hwdata_nxt[s]  = m_hwdata[o];
        s_hmaster_nxt[s] = o;
      end
    end
  end

  // Master side: one-cycle ready with the slave's answer, or an error on a miss
  always_comb
  begin
    m_hready_nxt = '0;
    m_hresp_nxt  = '0;
    m_hrdata_nxt = m_hrdata_r;
    for (int s = 0; s < NS; s++)
    begin
      if (sdone[s])
      begin
        m_hready_nxt[s_hmaster_r[s]] = 1'b1;
        m_hresp_nxt[s_hmaster_r[s]]  = s_hresp[s];
        m_hrdata_nxt[s_hmaster_r[s]] = s_hrdata[s];
      end
    end
    for (int m = 0; m < NM; m++)
    begin
      if (act[m] && !dec_hit[m] && !m_hready_r[m])
      begin
        m_hready_nxt[m] = 1'b1;
        m_hresp_nxt[m]  = 1'b1;
      end
    end
  end

  // Output registers of both sides
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      m_hready_r  <= '0;
      m_hresp_r   <= '0;
      m_hrdata_r  <= '0;
      s_hsel_r    <= '0;
      s_haddr_r   <= '0;
      s_htrans_r  <= '0;
      s_hwrite_r  <= '0;
      s_hsize_r   <= '0;
      s_hburst_r  <= '0;
      s_hwdata_r  <= '0;
      s_hmaster_r <= '0;
    end
    else
    begin
      m_hready_r  <= m_hready_nxt;
      m_hresp_r   <= m_hresp_nxt;
      m_hrdata_r  <= m_hrdata_nxt;
      s_hsel_r    <= s_hsel_nxt;
      s_haddr_r   <= s_haddr_nxt;
      s_htrans_r  <= s_htrans_nxt;
      s_hwrite_r  <= s_hwrite_nxt;
      s_hsize_r   <= s_hsize_nxt;
      s_hburst_r  <= s_hburst_nxt;
      s_hwdata_r  <= s_hwdata_nxt;
      s_hmaster_r <= s_hmaster_nxt;
    end
  end

  assign m_hready      = m_hready_r;
  assign m_hresp       = m_hresp_r;
  assign m_hrdata      = m_hrdata_r;
  assign s_hsel        = s_hsel_r;
  assign s_haddr       = s_haddr_r;
  assign s_htrans      = s_htrans_r;
  assign s_hwrite      = s_hwrite_r;
  assign s_hsize       = s_hsize_r;
  assign s_hburst      = s_hburst_r;
  assign s_hwdata      = s_hwdata_r;
  assign s_hmaster     = s_hmaster_r;
  assign boot_from_rom = boot_rom_r;
endmodule
`default_nettype wire

// *** sixbm_slave_model.sv ***
// Behavioural slave standing on each slave port of the matrix
`timescale 1ns/100ps
`default_nettype none
module sixbm_slave_model #(
  parameter logic [3:0] SID = 4'h0
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  wait_n,
  output logic             hready,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  logic [1:0]  cnt_r;
  logic [1:0]  cnt_nxt;
  logic [31:0] last_r;
  logic [31:0] last_nxt;

  // Reply after wait_n wait states; data carries the slave number so a wrong route shows
  assign hready = hsel && (cnt_r == wait_n);
  assign hresp  = 1'h0;
  // Outside a reply the data bus toggles, so stale data never looks valid
  assign hrdata = hready ? {haddr[31:4], SID} : ~last_r;

  // Next wait count and last bus value
  always_comb
  begin
    cnt_nxt  = (hsel && !hready) ? cnt_r + 2'h1 : 2'h0;
    last_nxt = hrdata;
  end

  // State registers
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_r  <= 2'h0;
      last_r <= 32'h0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      last_r <= last_nxt;
    end
  end
endmodule
`default_nettype wire

// *** sixbm_matrix_assertions.sv ***
// Concurrent checks on the bus matrix ports
`timescale 1ns/100ps
`default_nettype none
module sixbm_matrix_assertions #(
  parameter int DW    = 32,
  parameter int SLOTW = sixbm_pkg::SLOTW,
  parameter int NM    = sixbm_pkg::NM,
  parameter int NS    = sixbm_pkg::NS
) (
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  input wire logic [NM-1:0][1:0]   m_htrans,
  input wire logic [NM-1:0][31:0]  m_haddr,
  input wire logic [NM-1:0]        m_hwrite,
  input wire logic [NM-1:0][2:0]   m_hsize,
  input wire logic [NM-1:0][2:0]   m_hburst,
  input wire logic [NM-1:0][DW-1:0] m_hwdata,
  input wire logic [NM-1:0]        m_hready,
  input wire logic [NM-1:0]        m_hresp,
  input wire logic [NM-1:0][DW-1:0] m_hrdata,
  input wire logic [NS-1:0]        s_hsel,
  input wire logic [NS-1:0][31:0]  s_haddr,
  input wire logic [NS-1:0][1:0]   s_htrans,
  input wire logic [NS-1:0]        s_hwrite,
  input wire logic [NS-1:0][2:0]   s_hsize,
  input wire logic [NS-1:0][2:0]   s_hburst,
  input wire logic [NS-1:0][DW-1:0] s_hwdata,
  input wire logic [NS-1:0][2:0]   s_hmaster,
  input wire logic [NS-1:0]        s_hready,
  input wire logic [NS-1:0]        s_hresp,
  input wire logic [NS-1:0][DW-1:0] s_hrdata,
  input wire logic                 boot_from_rom
);
  logic [3:0] up_r;
  logic [3:0] up_nxt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Cycles since reset, saturating; the boot pin capture is long done at the top
  always_comb
    up_nxt = (up_r == 4'hF) ? up_r : up_r + 4'h1;
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      up_r <= 4'h0;
    else
      up_r <= up_nxt;

  a_boot_steady:
    assert property (up_r == 4'hF |-> $stable(boot_from_rom)) else $error("boot choice changed");
  a_peri_path:
    assert property (s_hsel[4] |-> s_hmaster[4] < 3'h4) else $error("peripherals from masters 4-5");
  a_rom_path:
    assert property (s_hsel[2] |-> s_hmaster[2] < 3'h4) else $error("ROM port from masters 4-5");

  // Master side answers
  for (genvar g = 0; g < NM; g++)
  begin : g_m
    a_err_unmapped:
      assert property (m_htrans[g][1] && !m_hready[g] && m_haddr[g][31:28] inside {[4'h8:4'hE]}
        |=> m_hready[g] && m_hresp[g]) else $error("unused bank not refused");
    a_done_pulse:
      assert property (m_hready[g] |=> !m_hready[g]) else $error("completion longer than a cycle");
    a_resp_req:
      assert property (m_hready[g] |-> $past(m_htrans[g][1])) else $error("answer without request");
  end

  // Slave side presentation
  for (genvar s = 0; s < NS; s++)
  begin : g_s
    a_sel_hold:
      assert property (s_hsel[s] && !s_hready[s] |=> s_hsel[s] && $stable(s_haddr[s])
        && $stable(s_hmaster[s])) else $error("transfer dropped while waiting");
    a_sel_req:
      assert property (s_hsel[s] |-> m_htrans[s_hmaster[s]][1]) else $error("owner not requesting");
    a_attr_fwd:
      assert property (s_hsel[s] |-> s_haddr[s] == m_haddr[s_hmaster[s]] && s_htrans[s] == m_htrans[s_hmaster[s]]
        && s_hwrite[s] == m_hwrite[s_hmaster[s]] && s_hwdata[s] == m_hwdata[s_hmaster[s]]
        && s_hsize[s] == m_hsize[s_hmaster[s]] && s_hburst[s] == m_hburst[s_hmaster[s]])
        else $error("transfer attributes not forwarded");
    a_fwd_resp:
      assert property (s_hsel[s] && s_hready[s] |=> m_hready[$past(s_hmaster[s])]
        && m_hresp[$past(s_hmaster[s])] == $past(s_hresp[s])
        && m_hrdata[$past(s_hmaster[s])] == $past(s_hrdata[s])) else $error("reply not forwarded");
  end
endmodule

bind sixbm_matrix sixbm_matrix_assertions #(.DW(DW), .SLOTW(SLOTW)) u_chk (.*);
`default_nettype wire

// *** sixbm_matrix_tb.sv ***
// Self-checking bench for the six-layer bus matrix
`timescale 1ns/100ps
`default_nettype none
module sixbm_matrix_tb;
  logic                  clk_sys;
  logic                  sys_rst;
  logic                  boot_memory_select;
  logic                  remap_en;
  logic [4:0]            arb_rr_mode;
  logic [4:0][1:0]       arb_dflt_mode;
  logic [4:0][2:0]       arb_dflt_master;
  logic [4:0][7:0]       arb_slot_limit;
  logic [5:0][1:0]       m_htrans;
  logic [5:0][31:0]      m_haddr;
  logic [5:0]            m_hwrite;
  logic [5:0][2:0]       m_hsize;
  logic [5:0][2:0]       m_hburst;
  logic [5:0][31:0]      m_hwdata;
  logic [5:0]            m_hready;
  logic [5:0]            m_hresp;
  logic [5:0][31:0]      m_hrdata;
  logic [4:0]            s_hsel;
  logic [4:0][31:0]      s_haddr;
  logic [4:0][2:0]       s_hmaster;
  logic [4:0]            s_hready;
  logic [4:0]            s_hresp;
  logic [4:0][31:0]      s_hrdata;
  logic                  boot_from_rom;
  logic [4:0][1:0]       s_wait;
  logic                  do_wr;
  int                    fail_count;
  int                    n_compared;
  int                    cyc;
  int                    lat [6];
  int                    done [6];

  sixbm_matrix dut (.*, .s_htrans(), .s_hwrite(), .s_hsize(), .s_hburst(), .s_hwdata());

  // One slave model per slave port
  for (genvar s = 0; s < 5; s++)
  begin : g_sl
    sixbm_slave_model #(.SID(4'(s))) u_sl (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .hsel    (s_hsel[s]),
      .haddr   (s_haddr[s]),
      .wait_n  (s_wait[s]),
      .hready  (s_hready[s]),
      .hresp   (s_hresp[s]),
      .hrdata  (s_hrdata[s])
    );
  end

  initial
  begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Cycle count and hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Expected slave for a master and address, 7 meaning refused
  function automatic int exp_sl(input int m, input logic [31:0] a);
    if (a[31:28] >= 4'h1 && a[31:28] <= 4'h7)
      return 3;
    if (a[31:28] == 4'hF)
      return m < 4 ? 4 : 7;
    if (a[31:28] != 4'h0)
      return 7;
    case (a[27:20])
      8'h00: return remap_en ? 0 : boot_memory_select ? (m < 4 ? 2 : 7) : 3;
      8'h01: return m < 4 ? 2 : 7;
      8'h02: return 0;
      8'h03: return 1;
      8'h05: return m < 2 ? 2 : 7;
      default: return 7;
    endcase
  endfunction

  // One transfer: entered at an edge, held until the completion pulse; keep chains a burst beat
  task automatic acc(input int m, input logic [31:0] a, input bit keep = 0,
                     input logic [1:0] tr = sixbm_pkg::TR_NONSEQ);
    int sl;
    int n;
    sl = exp_sl(m, a);
    m_htrans[m] <= tr;
    m_haddr[m]  <= a;
    m_hwrite[m] <= do_wr;
    m_hwdata[m] <= ~a;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (m_hready[m] !== 1'h1 && n < 300);
    // A transfer that never completes is a mismatch and ends the run
    if (n >= 300)
    begin
      fail_count++;
      test_done();
    end
    lat[m]  = n;
    done[m] = cyc;
    chk("resp", 32'(m_hresp[m]), 32'(sl == 7));
    if (sl < 7 && !do_wr)
      chk("rdata", m_hrdata[m], {a[31:4], 4'(sl)});
    @(posedge clk_sys);
    if (!keep)
    begin
      m_htrans[m] <= 2'h0;
      @(posedge clk_sys);
    end
  endtask

  task automatic rst_seq;
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    repeat (5) @(posedge clk_sys);
  endtask

  // Every boot pin and remap pairing, then accesses near zero from masters 1 and 4; writes go in under remap
  task automatic t_boot;
    for (int k = 0; k < 4; k++)
    begin
      boot_memory_select <= k[1];
      remap_en           <= k[0];
      do_wr               = k[0];
      rst_seq();
      chk("boot", 32'(boot_from_rom), 32'(k[1]));
      acc(1, 32'h0000_0100);
      acc(4, 32'h0000_0200);
    end
    do_wr = 1'h0;
  endtask

  // Whole address map from every master, slaves with mixed wait states
  task automatic t_map;
    logic [31:0] ad [10] = '{32'h0000_0040, 32'h0010_0040, 32'h0020_0040, 32'h0030_0040, 32'h0050_0040,
                             32'h0040_0000, 32'h1000_0040, 32'h7FF0_0000, 32'hF000_0040, 32'h8000_0000};
    s_wait <= {2'h3, 2'h0, 2'h2, 2'h1, 2'h0};
    for (int m = 0; m < 6; m++)
      for (int i = 0; i < 10; i++)
        acc(m, ad[i]);
  endtask

  // Four masters on four free slaves at once
  task automatic t_para;
    s_wait <= '0;
    fork
      acc(0, 32'h0020_0000);
      acc(2, 32'h0030_0000);
      acc(3, 32'hF000_0000);
      acc(5, 32'h2000_0000);
    join
    for (int m = 0; m < 6; m++)
      if (m != 1 && m != 4)
        chk("para", 32'(lat[m]), 32'h3);
  endtask

  // Three masters collide: fixed order on slave 1, round robin on slave 3
  task automatic t_arb;
    logic [31:0] a;
    s_wait      <= {2'h0, 2'h2, 2'h0, 2'h2, 2'h0};
    arb_rr_mode <= 5'h08;
    acc(0, 32'h1000_0000);
    for (int s = 1; s < 4; s += 2)
    begin
      a = (s == 1) ? 32'h0030_0000 : 32'h1000_0000;
      fork
        acc(0, a);
        acc(1, a);
        acc(2, a);
      join
      chk("order", 32'(s == 1 ? (done[0] < done[1] && done[1] < done[2])
                              : (done[1] < done[2] && done[2] < done[0])), 32'h1);
    end
  endtask

  // Default master options: a parked grant saves one cycle
  task automatic t_park;
    s_wait          <= '0;
    arb_dflt_master <= {5{3'h2}};
    for (int d = 0; d < 3; d++)
    begin
      arb_dflt_mode[3] <= 2'(d);
      acc(2, 32'h1000_0000);
      acc(2, 32'h1000_0000);
      chk("park", 32'(lat[2]), d == 0 ? 32'h3 : 32'h2);
    end
  endtask

  // Long incrementing burst on slave 0 against a late master, without and with a slot limit
  task automatic t_slot;
    arb_dflt_mode <= '0;
    m_hburst[0]   <= 3'h1;
    for (int l = 0; l < 2; l++)
    begin
      arb_slot_limit[0] <= l ? 8'h04 : 8'h00;
      fork
        for (int i = 0; i < 12; i++)
          acc(0, 32'h0020_0000 + 32'(4 * i), i < 11, i ? sixbm_pkg::TR_SEQ : sixbm_pkg::TR_NONSEQ);
        begin
          repeat (6) @(posedge clk_sys);
          acc(5, 32'h0020_0100);
        end
      join
      chk("slot", 32'(done[5] < done[0]), 32'(l));
    end
    m_hburst[0] <= 3'h0;
  endtask

  initial
  begin
    sys_rst            = 1'h1;
    boot_memory_select = 1'h1;
    remap_en           = 1'h0;
    arb_rr_mode        = '0;
    arb_dflt_mode      = '0;
    arb_dflt_master    = '0;
    arb_slot_limit     = '0;
    m_htrans           = '0;
    m_haddr            = '0;
    m_hwrite           = '0;
    m_hsize            = {6{3'h2}};
    m_hburst           = '0;
    m_hwdata           = '0;
    s_wait             = '0;
    do_wr              = 1'h0;
    @(posedge clk_sys);
    t_boot();
    t_map();
    t_para();
    t_arb();
    t_park();
    t_slot();
    test_done();
  end
endmodule
`default_nettype wire
